// [logic/hbp_pkg.sv]
package hbp_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int PC_W = 3;
    localparam int UPPER_W = 4;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 4;
    // Decoder input bus: A0..A15, four upper inputs, page, read, write, strobe, byte-high.
    localparam int DEC_IN_W = ADDR_W + UPPER_W + PAGE_W + 4;
    // Each cell uses two bits: care and value.
    localparam int TERM_W = 2 * DEC_IN_W;
    // First-array outputs: eight program banks, RAM, I/O ports, three track controls.
    localparam int ARR_A_OUTS = 13;
    localparam int CS_OUTS = 8;
    localparam int CS_TERMS = 4;
    localparam int CS_WIDE = 4;
    localparam int CS_NARROW_TERMS = 2;

    // ------------------------------------------------------------------
    // Decoder input positions
    // ------------------------------------------------------------------
    localparam int DI_UPPER = ADDR_W;
    localparam int DI_PAGE = DI_UPPER + UPPER_W;
    localparam int DI_RD = DI_PAGE + PAGE_W;
    localparam int DI_WR = DI_RD + 1;
    localparam int DI_STROBE = DI_WR + 1;
    localparam int DI_BHE = DI_STROBE + 1;

    // First-array output positions.
    localparam int AO_RAM = 8;
    localparam int AO_IOPORT = 9;
    localparam int AO_TRK_IN = 10;
    localparam int AO_TRK_OUT1 = 11;
    localparam int AO_TRK_OUT2 = 12;

    // ------------------------------------------------------------------
    // Bus modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        HBP_MUX8 = 4'h1,
        HBP_MUX16 = 4'h2,
        HBP_NMUX8 = 4'h4,
        HBP_NMUX16 = 4'h8
    } hbp_mode_t;

    // Erased configuration reads as zero.
    localparam logic CFG_ERASED = 1'h0;

endpackage : hbp_pkg

// [logic/hbp_port_core.sv]
`timescale 1ns/1ps
module hbp_port_core
    import hbp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Static configuration.
    input wire logic bus_mux_select_bit_i,
    input wire logic data_width_select_i,
    input wire logic latch_strobe_polarity_i,
    input wire logic port_a_track_select_i,
    input wire logic [PORT_W-1:0] port_a_bit_function_i,
    input wire logic [PORT_W-1:0] port_a_output_type_i,
    input wire logic [PORT_W-1:0] port_b_bit_function_i,
    input wire logic [PORT_W-1:0] port_b_output_type_i,
    input wire logic [PC_W-1:0] port_c_bit_function_i,
    input wire logic [UPPER_W-1:0] upper_input_kind_select_i,
    input wire logic upper_address_latch_option_i,
    // Decoder array contents: per term, care mask high half, value low half.
    input wire logic [ARR_A_OUTS*TERM_W-1:0] arr_a_terms_i,
    input wire logic [CS_OUTS*CS_TERMS*TERM_W-1:0] arr_b_terms_i,
    input wire logic [PC_W*TERM_W-1:0] arr_c_terms_i,
    // Page and internal port registers.
    input wire logic [PAGE_W-1:0] page_i,
    input wire logic [PORT_W-1:0] port_a_dir_i,
    input wire logic [PORT_W-1:0] port_a_data_i,
    input wire logic [PORT_W-1:0] port_b_dir_i,
    input wire logic [PORT_W-1:0] port_b_data_i,
    // Host pins.
    input wire logic address_strobe_alias_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic byte_high_enable_n_i,
    input wire logic [PORT_W-1:0] ad_lo_i,
    output logic [PORT_W-1:0] ad_lo_o,
    output logic ad_lo_oe_n_o,
    input wire logic [PORT_W-1:0] ad_hi_i,
    output logic [PORT_W-1:0] ad_hi_o,
    output logic ad_hi_oe_n_o,
    input wire logic [UPPER_W-1:0] upper_i,
    // Read data from the internal memories.
    input wire logic [2*PORT_W-1:0] rd_data_i,
    output logic [2*PORT_W-1:0] wr_data_o,
    output logic wr_lo_o,
    output logic wr_hi_o,
    // Ports.
    input wire logic [PORT_W-1:0] port_a_i,
    output logic [PORT_W-1:0] port_a_o,
    output logic [PORT_W-1:0] port_a_oe_n_o,
    input wire logic [PORT_W-1:0] port_b_i,
    output logic [PORT_W-1:0] port_b_o,
    output logic [PORT_W-1:0] port_b_oe_n_o,
    input wire logic [PC_W-1:0] port_c_i,
    output logic [PC_W-1:0] port_c_o,
    output logic [PC_W-1:0] port_c_oe_n_o,
    // Status.
    output logic [ARR_A_OUTS-1:0] internal_sel_o,
    output logic [ADDR_W-1:0] latched_addr_o,
    output hbp_mode_t bus_mode_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYN_W = 4 + 2 * PORT_W + UPPER_W + 3 * PORT_W + PC_W;
    logic [SYN_W-1:0] syn1_q;
    logic [SYN_W-1:0] syn2_q;
    // Read, write and byte-high start inactive and the strobe low, so no read or write is seen after reset.
    localparam logic [SYN_W-1:0] SYN_IDLE = {1'b0, 3'h7, {(SYN_W-4){1'b0}}};

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            syn1_q <= SYN_IDLE;
            syn2_q <= SYN_IDLE;
        end else begin
            syn1_q <= {address_strobe_alias_i, rd_n_i, wr_n_i, byte_high_enable_n_i,
                       ad_lo_i, ad_hi_i, upper_i, port_a_i, port_b_i, port_c_i,
                       {PORT_W{1'b0}}};
            syn2_q <= syn1_q;
        end
    end

    logic strobe_pin, rd_n, wr_n, bhe_n;
    logic [PORT_W-1:0] ad_lo, ad_hi, pa_in, pb_in, unused_pad;
    logic [UPPER_W-1:0] up_in;
    logic [PC_W-1:0] pc_in;
    assign {strobe_pin, rd_n, wr_n, bhe_n, ad_lo, ad_hi, up_in, pa_in, pb_in, pc_in,
            unused_pad} = syn2_q;

    // ------------------------------------------------------------------
    // Synchroniser fill after reset
    // ------------------------------------------------------------------
    // The strobe edge detector stays blind until real pin levels reach it.
    logic [1:0] fill_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            fill_q <= '0;
        end else begin
            fill_q <= {fill_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic muxed, wide;
    assign muxed = bus_mux_select_bit_i;
    assign wide = data_width_select_i;

    always_comb begin
        case ({muxed, wide})
            2'h0: bus_mode_o = HBP_NMUX8;
            2'h1: bus_mode_o = HBP_NMUX16;
            2'h2: bus_mode_o = HBP_MUX8;
            default: bus_mode_o = HBP_MUX16;
        endcase
    end

    // ------------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------------
    logic strobe_act, strobe_act_q, strobe_fall;
    assign strobe_act = strobe_pin ^ latch_strobe_polarity_i;
    assign strobe_fall = strobe_act_q && !strobe_act;

    logic [ADDR_W-1:0] addr_q;
    logic [UPPER_W-1:0] upper_q;
    logic bhe_n_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            strobe_act_q <= 1'b0;
            addr_q <= '0;
            upper_q <= '0;
            bhe_n_q <= 1'b1;
        end else begin
            strobe_act_q <= strobe_act && fill_q[1];
            if (muxed && strobe_fall) begin
                addr_q <= {ad_hi, ad_lo};
                upper_q <= up_in;
                bhe_n_q <= bhe_n;
            end
        end
    end

    // Address seen by the decoders: latched when multiplexed, live otherwise.
    logic [ADDR_W-1:0] addr_eff;
    logic [UPPER_W-1:0] upper_eff, upper_live;
    logic bhe_eff;
    assign addr_eff = muxed ? addr_q : {ad_hi, ad_lo};
    assign bhe_eff = muxed ? bhe_n_q : bhe_n;
    assign upper_live = {up_in[UPPER_W-1], pc_in};
    always_comb begin
        for (int i = 0; i < UPPER_W; i++) begin
            // Logic inputs always pass through; address inputs obey the latch option.
            if (upper_input_kind_select_i[i] && upper_address_latch_option_i) begin
                upper_eff[i] = muxed ? upper_q[i] : upper_live[i];
            end else begin
                upper_eff[i] = upper_live[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared decoder input bus
    // ------------------------------------------------------------------
    logic [DEC_IN_W-1:0] dec_in;
    // Without multiplexing the strobe is a logic input that also blocks reads and writes.
    assign dec_in = {bhe_eff, strobe_act, ~wr_n, ~rd_n, page_i, upper_eff, addr_eff};

    function automatic logic term_hit(input logic [TERM_W-1:0] t, input logic [DEC_IN_W-1:0] x);
        // Upper half marks inputs that matter, lower half the required value.
        term_hit = ((x ^ t[DEC_IN_W-1:0]) & t[TERM_W-1:DEC_IN_W]) == '0;
    endfunction : term_hit

    // ------------------------------------------------------------------
    // First array: internal selects
    // ------------------------------------------------------------------
    logic [ARR_A_OUTS-1:0] sel_a;
    genvar g;
    generate
        for (g = 0; g < ARR_A_OUTS; g++) begin : g_arr_a
            assign sel_a[g] = term_hit(arr_a_terms_i[g*TERM_W +: TERM_W], dec_in);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Second array: chip selects on port B, outputs on port C
    // ------------------------------------------------------------------
    logic [CS_OUTS-1:0] cs_n;
    logic [PC_W-1:0] pc_term;
    generate
        for (g = 0; g < CS_OUTS; g++) begin : g_cs
            localparam int NT = (g < CS_WIDE) ? CS_TERMS : CS_NARROW_TERMS;
            logic [NT-1:0] hits;
            for (genvar t = 0; t < NT; t++) begin : g_t
                assign hits[t] =
                    term_hit(arr_b_terms_i[(g*CS_TERMS+t)*TERM_W +: TERM_W], dec_in);
            end
            assign cs_n[g] = ~(|hits);
        end
        for (g = 0; g < PC_W; g++) begin : g_pc
            assign pc_term[g] = term_hit(arr_c_terms_i[g*TERM_W +: TERM_W], dec_in);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Host data path
    // ------------------------------------------------------------------
    logic rd_act, wr_act, hi_xfer;
    assign rd_act = !rd_n && !strobe_act;
    assign wr_act = !wr_n && !strobe_act;
    assign hi_xfer = muxed && wide && !bhe_eff;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ad_lo_o <= '0;
            ad_hi_o <= '0;
            ad_lo_oe_n_o <= 1'b1;
            ad_hi_oe_n_o <= 1'b1;
            wr_data_o <= '0;
            wr_lo_o <= 1'b0;
            wr_hi_o <= 1'b0;
            internal_sel_o <= '0;
            latched_addr_o <= '0;
        end else begin
            internal_sel_o <= sel_a;
            latched_addr_o <= addr_eff;
            ad_lo_o <= rd_data_i[PORT_W-1:0];
            ad_hi_o <= rd_data_i[2*PORT_W-1:PORT_W];
            ad_lo_oe_n_o <= !(muxed && rd_act);
            ad_hi_oe_n_o <= !(hi_xfer && rd_act);
            // Non-multiplexed data arrives on ports A and B.
            wr_data_o <= muxed ? {ad_hi, ad_lo} : {pb_in, pa_in};
            wr_lo_o <= wr_act;
            wr_hi_o <= wr_act && wide && !bhe_eff;
        end
    end

    // ------------------------------------------------------------------
    // Port A
    // ------------------------------------------------------------------
    logic trk_out, trk_in;
    assign trk_out = (sel_a[AO_TRK_OUT1] && strobe_act) || sel_a[AO_TRK_OUT2];
    assign trk_in = sel_a[AO_TRK_IN] && rd_act;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            port_a_o <= '0;
            port_a_oe_n_o <= '1;
        end else begin
            for (int i = 0; i < PORT_W; i++) begin
                logic val, drv;
                val = 1'b0;
                drv = 1'b0;
                if (!muxed) begin
                    val = rd_data_i[i];
                    drv = rd_act;
                end else if (port_a_track_select_i) begin
                    val = ad_lo[i];
                    drv = trk_out;
                end else if (port_a_bit_function_i[i]) begin
                    val = addr_q[i];
                    drv = 1'b1;
                end else begin
                    val = port_a_data_i[i];
                    drv = port_a_dir_i[i];
                end
                port_a_o[i] <= val;
                // Open-drain only pulls low.
                port_a_oe_n_o[i] <= !(drv && !(port_a_output_type_i[i] && val));
            end
        end
    end

    // ------------------------------------------------------------------
    // Port B
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            port_b_o <= '0;
            port_b_oe_n_o <= '1;
        end else begin
            for (int i = 0; i < PORT_W; i++) begin
                logic val, drv;
                val = 1'b0;
                drv = 1'b0;
                if (!muxed && wide) begin
                    val = rd_data_i[PORT_W+i];
                    drv = rd_act && !bhe_eff;
                end else if (port_b_bit_function_i[i]) begin
                    val = port_b_data_i[i];
                    drv = port_b_dir_i[i];
                end else begin
                    val = cs_n[i];
                    drv = 1'b1;
                end
                port_b_o[i] <= val;
                port_b_oe_n_o[i] <= !(drv && !(port_b_output_type_i[i] && val));
            end
        end
    end

    // ------------------------------------------------------------------
    // Port C, independent of bus mode
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            port_c_o <= '0;
            port_c_oe_n_o <= '1;
        end else begin
            port_c_o <= ~pc_term;
            port_c_oe_n_o <= ~port_c_bit_function_i;
        end
    end

endmodule : hbp_port_core

// [testbench/hbp_port_core_sva.sv]
`timescale 1ns/1ps
module hbp_port_core_sva
    import hbp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic bus_mux_select_bit_i,
    input wire logic data_width_select_i,
    input wire logic latch_strobe_polarity_i,
    input wire logic [PORT_W-1:0] port_a_output_type_i,
    input wire logic address_strobe_alias_i,
    input wire logic rd_n_i,
    input wire logic byte_high_enable_n_i,
    input wire logic [PORT_W-1:0] ad_lo_i,
    input wire logic [PORT_W-1:0] ad_hi_i,
    input wire logic [2*PORT_W-1:0] rd_data_i,
    input wire logic [PORT_W-1:0] ad_lo_o,
    input wire logic ad_lo_oe_n_o,
    input wire logic ad_hi_oe_n_o,
    input wire logic [PORT_W-1:0] port_a_o,
    input wire logic [PORT_W-1:0] port_a_oe_n_o,
    input wire logic [ADDR_W-1:0] latched_addr_o,
    input wire hbp_mode_t bus_mode_o
);
    logic [3:0] up_q;
    logic [ADDR_W-1:0] cap_q;

    // Settle time after reset, so a synchroniser refill is not taken for a strobe edge.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    end

    // Address seen on the pins while the strobe is inactive.
    always_ff @(posedge sys_clk_i) begin
        if (address_strobe_alias_i == latch_strobe_polarity_i) cap_q <= {ad_hi_i, ad_lo_i};
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_mode;
        bus_mode_o == (bus_mux_select_bit_i ? (data_width_select_i ? HBP_MUX16 : HBP_MUX8)
            : (data_width_select_i ? HBP_NMUX16 : HBP_NMUX8));
    endproperty
    property p_trail;
        bus_mux_select_bit_i && $changed(address_strobe_alias_i)
            && address_strobe_alias_i == latch_strobe_polarity_i
            |-> ##[2:4] latched_addr_o == cap_q;
    endproperty
    property p_hold;
        (up_q == 4'hF && bus_mux_select_bit_i && $stable(address_strobe_alias_i)) [*6]
            |-> $stable(latched_addr_o);
    endproperty
    property p_lo_quiet;
        !bus_mux_select_bit_i |-> ad_lo_oe_n_o;
    endproperty
    property p_hi_quiet;
        bus_mode_o != HBP_MUX16 |-> ad_hi_oe_n_o;
    endproperty
    property p_lo_drive;
        (bus_mux_select_bit_i && !rd_n_i) [*5] |-> !ad_lo_oe_n_o;
    endproperty
    property p_lo_data;
        (bus_mux_select_bit_i && !rd_n_i) [*5] |-> ad_lo_o == $past(rd_data_i[7:0]);
    endproperty
    property p_hi_drive;
        (bus_mode_o == HBP_MUX16 && !rd_n_i && !byte_high_enable_n_i) [*5] |-> !ad_hi_oe_n_o;
    endproperty
    property p_pa_data;
        (!bus_mux_select_bit_i && port_a_output_type_i == 8'h00 && !rd_n_i) [*5]
            |-> port_a_oe_n_o == 8'h00 && port_a_o == $past(rd_data_i[7:0]);
    endproperty

    a_mode: assert property (p_mode) else $error("bus mode wrong");
    a_trail: assert property (p_trail) else $error("address not taken");
    a_hold: assert property (p_hold) else $error("address moved");
    a_lo_quiet: assert property (p_lo_quiet) else $error("low pins driven");
    a_hi_quiet: assert property (p_hi_quiet) else $error("high pins driven");
    a_lo_drive: assert property (p_lo_drive) else $error("low pins idle");
    a_lo_data: assert property (p_lo_data) else $error("low data wrong");
    a_hi_drive: assert property (p_hi_drive) else $error("high pins idle");
    a_pa_data: assert property (p_pa_data) else $error("port A data wrong");

    c_trail: cover property (p_trail);
    c_hi: cover property (bus_mode_o == HBP_MUX16 && !ad_hi_oe_n_o);
    c_pa: cover property (!bus_mux_select_bit_i && !rd_n_i && port_a_oe_n_o == 8'h00);
endmodule : hbp_port_core_sva

// [testbench/hbp_host_model.sv]
`timescale 1ns/1ps
module hbp_host_model (
    input wire logic clk_i,
    input wire logic pol_i,
    input wire logic mux_i,
    input wire logic w16_i,
    output logic strobe_o,
    output logic rd_n_o,
    output logic bhe_n_o,
    output logic [7:0] lo_o,
    output logic [7:0] hi_o
);
    logic act;

    assign strobe_o = act ^ pol_i;

    initial begin
        act = 1'b0;
        rd_n_o = 1'b1;
        bhe_n_o = 1'b1;
        {hi_o, lo_o} = 16'h0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    // Address phase, then a read left pending until to_write or done is called.
    task automatic access(input logic [15:0] a, input logic bhe_n);
        step(1);
        {hi_o, lo_o} = a;
        bhe_n_o = bhe_n;
        act = 1'b1;
        step(4);
        act = 1'b0;
        step(4);
        if (mux_i) begin
            lo_o = ~a[7:0];
            if (w16_i) hi_o = ~a[15:8];
        end
        rd_n_o = 1'b0;
        step(8);
    endtask : access

    task automatic to_write();
        rd_n_o = 1'b1;
    endtask : to_write

    task automatic done();
        rd_n_o = 1'b1;
        bhe_n_o = 1'b1;
    endtask : done
endmodule : hbp_host_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import hbp_pkg::*;
    logic sys_clk_i, rstn_i, bus_mux_select_bit_i, data_width_select_i, latch_strobe_polarity_i;
    logic port_a_track_select_i, upper_address_latch_option_i, wr_n_i, address_strobe_alias_i;
    logic rd_n_i, byte_high_enable_n_i, ad_lo_oe_n_o, ad_hi_oe_n_o, wr_lo_o, wr_hi_o;
    logic [PORT_W-1:0] port_a_bit_function_i, port_a_output_type_i, port_b_bit_function_i;
    logic [PORT_W-1:0] port_b_output_type_i, port_a_dir_i, port_a_data_i, port_b_dir_i;
    logic [PORT_W-1:0] port_b_data_i, ad_lo_i, ad_lo_o, ad_hi_i, ad_hi_o, port_a_i, port_a_o;
    logic [PORT_W-1:0] port_a_oe_n_o, port_b_i, port_b_o, port_b_oe_n_o;
    logic [PC_W-1:0] port_c_bit_function_i, port_c_i, port_c_o, port_c_oe_n_o;
    logic [UPPER_W-1:0] upper_input_kind_select_i, upper_i;
    logic [ARR_A_OUTS*TERM_W-1:0] arr_a_terms_i;
    logic [CS_OUTS*CS_TERMS*TERM_W-1:0] arr_b_terms_i;
    logic [PC_W*TERM_W-1:0] arr_c_terms_i;
    logic [PAGE_W-1:0] page_i;
    logic [2*PORT_W-1:0] rd_data_i, wr_data_o;
    logic [ARR_A_OUTS-1:0] internal_sel_o;
    logic [ADDR_W-1:0] latched_addr_o;
    hbp_mode_t bus_mode_o;
    logic [15:0] lfsr_q = 16'h0037;
    int n_errors = 0;
    int num_checks = 0;

    hbp_port_core hbp_port_core_i (.*);
    hbp_host_model hbp_host_model_i (.clk_i(sys_clk_i), .pol_i(latch_strobe_polarity_i),
        .mux_i(bus_mux_select_bit_i), .w16_i(data_width_select_i),
        .strobe_o(address_strobe_alias_i), .rd_n_o(rd_n_i), .bhe_n_o(byte_high_enable_n_i),
        .lo_o(ad_lo_i), .hi_o(ad_hi_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction : rnd

    // Returns the expected enable (high byte) and value (low byte) of one port.
    function automatic logic [15:0] io_exp(input logic [7:0] sel, alt, dir, dat, od);
        logic [7:0] v;
        v = (sel & alt) | (~sel & dat);
        return {(od & v) | ~(sel | dir), v};
    endfunction : io_exp

    // Term t of select i needs address bit i+t high.
    function automatic logic [7:0] cs_exp(input logic [15:0] a);
        cs_exp = 8'hFF;
        for (int i = 0; i < 8; i++) begin
            for (int t = 0; t < (i < 4 ? 4 : 2); t++) begin
                if (a[(i + t) % 16]) cs_exp[i] = 1'b0;
            end
        end
    endfunction : cs_exp

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic setup(input int m, input logic pol);
        logic [15:0] r;
        rstn_i = 1'b0;
        bus_mux_select_bit_i = (m < 2);
        data_width_select_i = m[0];
        latch_strobe_polarity_i = pol;
        {port_a_bit_function_i, port_b_bit_function_i} = rnd();
        {port_a_dir_i, port_a_data_i} = rnd();
        {port_b_dir_i, port_b_data_i} = rnd();
        {port_a_output_type_i, port_b_output_type_i} = m < 2 ? rnd() : 16'h0000;
        {port_a_i, port_b_i} = rnd();
        r = rnd();
        upper_i = r[3:0];
        r = rnd();
        {port_a_track_select_i, port_c_bit_function_i, upper_input_kind_select_i, page_i,
            port_c_i, upper_address_latch_option_i} = r;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk({ad_lo_oe_n_o, ad_hi_oe_n_o}, 16'h0003);
        rstn_i = 1'b1;
        chk(bus_mode_o, 16'h0001 << m);
    endtask : setup

    task automatic run_access(input logic [15:0] a, input logic bhe_n);
        logic [15:0] pa, pb, wd;
        logic hi_rd;
        rd_data_i = rnd();
        hbp_host_model_i.access(a, bhe_n);
        hi_rd = !bhe_n && data_width_select_i;
        chk(latched_addr_o, a);
        chk(ad_lo_oe_n_o, !bus_mux_select_bit_i);
        chk(ad_hi_oe_n_o, !(hi_rd && bus_mux_select_bit_i));
        pa = io_exp(8'hFF, rd_data_i[7:0], 8'hFF, 8'h00, 8'h00);
        if (bus_mux_select_bit_i) begin
            chk(ad_lo_o, rd_data_i[7:0]);
            if (hi_rd) chk(ad_hi_o, rd_data_i[15:8]);
            pa = io_exp(port_a_bit_function_i, a[7:0], port_a_dir_i, port_a_data_i,
                port_a_output_type_i);
            if (port_a_track_select_i) begin
                pa = io_exp({8{a[12]}}, ~a[7:0], 8'h00, 8'h00, port_a_output_type_i);
            end
        end
        pb = io_exp(~port_b_bit_function_i, cs_exp(a), port_b_dir_i, port_b_data_i,
            port_b_output_type_i);
        if (!bus_mux_select_bit_i && hi_rd) begin
            pb = io_exp(8'hFF, rd_data_i[15:8], 8'hFF, 8'h00, 8'h00);
        end
        chk({port_a_oe_n_o, port_a_o | pa[15:8]}, {pa[15:8], pa[7:0] | pa[15:8]});
        chk({port_b_oe_n_o, port_b_o | pb[15:8]}, {pb[15:8], pb[7:0] | pb[15:8]});
        chk({port_c_oe_n_o, port_c_o | ~port_c_bit_function_i},
            {~port_c_bit_function_i, a[10:8] | ~port_c_bit_function_i});
        chk(internal_sel_o, a[12:0]);
        hbp_host_model_i.to_write();
        wr_n_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        #1;
        wd = {data_width_select_i ? ~a[15:8] : a[15:8], ~a[7:0]};
        chk(wr_data_o, bus_mux_select_bit_i ? wd : {port_b_i, port_a_i});
        chk({wr_lo_o, wr_hi_o}, {1'b1, data_width_select_i && !bhe_n});
        wr_n_i = 1'b1;
        hbp_host_model_i.done();
    endtask : run_access

    initial begin
        logic [15:0] a;
        wr_n_i = 1'b1;
        rd_data_i = 16'h0000;
        for (int g = 0; g < ARR_A_OUTS; g++) begin
            arr_a_terms_i[g*TERM_W +: TERM_W] = {2{28'h1 << g}};
        end
        for (int i = 0; i < CS_OUTS * CS_TERMS; i++) begin
            arr_b_terms_i[i*TERM_W +: TERM_W] = (i < 16 || i % 4 < 2) ?
                {2{28'h1 << ((i / 4 + i % 4) % 16)}} : '0;
        end
        for (int k = 0; k < PC_W; k++) begin
            arr_c_terms_i[k*TERM_W +: TERM_W] = {28'h1 << (8 + k), 28'h0};
        end
        for (int k = 0; k < 8; k++) begin
            setup(k % 4, k[2]);
            for (int j = 0; j < 4; j++) begin
                a = j == 0 ? 16'h0000 : (j == 1 ? 16'hFFFF : rnd());
                run_access(a, k % 4 == 1 ? j[0] : k % 4 != 3);
            end
            $display("test mode %0d polarity %0d done", k % 4, k[2]);
        end
        end_of_test();
    end

    // The sequence needs about seven hundred and thirty cycles; this allows five thousand.
    initial begin
        #50000;
        n_errors++;
        end_of_test();
    end
endmodule : tb_top

bind hbp_port_core hbp_port_core_sva hbp_port_core_sva_i (.*);
